/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the idle exit and reset status block
// Assumes: Bus hready is the block's own hreadyout; WAKE_CYCLES shortened to 3
// Notes: Outputs are sampled on the falling edge so no edge race decides a compare
`timescale 1ns/100ps
module tb_top;
  import iers_pkg::*;
  localparam int WC = 3;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd_s;
  logic [31:0] rv;
  logic hreadyout;
  logic rdy_s;
  logic wdt_to = 1'b0;
  logic [7:0] irq = 8'h00;
  logic secondary_clock_run = 1'b0;
  logic reg_en = 1'b1;
  logic clk_loss = 1'b0;
  logic pext = 1'b1;
  logic pready = 1'b1;
  logic hr;
  iers_cpu_evt_t cev = '0;
  iers_rst_evt_t rev = '0;
  iers_clk_ctl_t cc;
  logic pf;
  logic sf;
  logic wres;
  logic vbr;
  logic wclr;
  logic wrst;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wake = 0;
  int n_vb = 0;
  int n_wclr = 0;
  int n_wrst = 0;

  always #5 hclk = ~hclk;

  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
    if (wres === 1'b1) n_wake++;
    if (vbr === 1'b1) n_vb++;
    if (wclr === 1'b1) n_wclr++;
    if (wrst === 1'b1) n_wrst++;
  end

  iers_top #(.IRQ_W(8), .WAKE_CYCLES(WC)) iers_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hr), .cpu_evt(cev), .rst_evt(rev), .wdt_timeout(wdt_to),
    .irq_flags(irq), .sec_osc_running(secondary_clock_run), .primary_osc_ready(pready),
    .primary_external_clock(pext), .regulator_enable(reg_en), .clock_loss(clk_loss),
    .clk_ctl(cc), .primary_clock_running_flag(pf), .secondary_clock_active_flag(sf),
    .wake_resume(wres), .vector_branch(vbr), .watchdog_clear(wclr), .watchdog_reset(wrst));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (rdy_s !== 1'b1 && k < 20);
    if (rdy_s !== 1'b1 || hr !== 1'b0) begin
      n_mismatch++;
      $display("BAD t=%0t bus answer missing or not OKAY", $time);
    end
    rv = rd_s;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0000_0000);
    chk(rv, e, w);
  endtask : rdc

  task automatic state_chk(input logic [2:0] e, input string w);
    bus(1'b0, ADDR_MODE_STATUS, 32'h0000_0000);
    chk({29'h0000_0000, rv[3:1]}, {29'h0000_0000, e}, w);
  endtask : state_chk

  task automatic out_chk(input logic [8:0] m, input logic [8:0] e, input string w);
    @(negedge hclk);
    chk({23'h00_0000, {cc, pf, sf} & m}, {23'h00_0000, e}, w);
    @(posedge hclk);
  endtask : out_chk

  task automatic cpulse(input iers_cpu_evt_t v);
    cev <= v;
    cyc(1);
    cev <= '0;
    cyc(2);
  endtask : cpulse

  task automatic rpulse(input iers_rst_evt_t v);
    rev <= v;
    cyc(1);
    rev <= '0;
    cyc(2);
  endtask : rpulse

  // Trigger is driven by the caller just before entry
  task automatic wake_chk(input int exp_vb, input string w);
    int n0;
    int v0;
    int k;
    n0 = n_wake;
    v0 = n_vb;
    k = 0;
    while (n_wake == n0 && k < 60) begin
      cyc(1);
      k++;
    end
    irq <= 8'h00;
    chk(32'(k >= WC && k <= WC + 4), 32'h0000_0001, w);
    chk(32'(n_vb - v0), 32'(exp_vb), w);
  endtask : wake_chk

  task automatic give_verdict;
    $display("Counts: checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status;
    rdc(ADDR_RESET_CAUSE, 32'h0000_003c, "status reset");
    rdc(ADDR_POWER_CTRL, 32'h0000_0000, "ctrl reset");
    rdc(8'h20, 32'h0000_0000, "unmapped read");
    bus(1'b1, ADDR_RESET_CAUSE, 32'h0000_00ff);
    rdc(ADDR_RESET_CAUSE, 32'h0000_00bf, "status set");
    bus(1'b1, ADDR_RESET_CAUSE, 32'h0000_0000);
    rdc(ADDR_RESET_CAUSE, 32'h0000_000c, "status ro bits");
    bus(1'b1, ADDR_RESET_CAUSE, 32'h0000_00b3);
    reg_en <= 1'b0;
    rdc(ADDR_RESET_CAUSE, 32'h0000_00be, "brown-out forced low");
    reg_en <= 1'b1;
    bus(1'b1, ADDR_RESET_CAUSE, 32'h0000_00b3);
    rpulse(3'b001);
    rdc(ADDR_RESET_CAUSE, 32'h0000_00af, "reset instr flag");
    rpulse(3'b010);
    rdc(ADDR_RESET_CAUSE, 32'h0000_008f, "mismatch flag");
    rpulse(3'b100);
    rdc(ADDR_RESET_CAUSE, 32'h0000_008e, "brown-out flag");
    wdt_to <= 1'b1;
    cyc(1);
    wdt_to <= 1'b0;
    cyc(3);
    chk(32'(n_wrst), 32'h0000_0001, "run time-out reset");
    rdc(ADDR_RESET_CAUSE, 32'h0000_0086, "time-out flag");
    $display("done t_status");
  endtask : t_status

  task automatic t_sleep;
    int c0;
    c0 = n_wclr;
    cpulse(2'b10);
    out_chk(9'h103, 9'h000, "sleep clocks");
    state_chk(3'h2, "sleep state");
    chk(32'(n_wclr - c0), 32'h0000_0001, "sleep clears wdt");
    rdc(ADDR_RESET_CAUSE, 32'h0000_008a, "sleep flags");
    wdt_to <= 1'b1;
    cyc(1);
    wdt_to <= 1'b0;
    wake_chk(0, "wdt wake");
    rdc(ADDR_RESET_CAUSE, 32'h0000_0082, "wake time-out flag");
    cpulse(2'b01);
    rdc(ADDR_RESET_CAUSE, 32'h0000_008e, "clear instr flags");
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0020);
    clk_loss <= 1'b1;
    cyc(1);
    clk_loss <= 1'b0;
    cyc(2);
    chk(32'(n_wclr - c0), 32'h0000_0003, "wdt clear count");
    $display("done t_sleep");
  endtask : t_sleep

  task automatic t_sec;
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0003);
    cpulse(2'b10);
    state_chk(3'h0, "sleep ignored");
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_000b);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, ADDR_INT_CTRL, 32'h0000_0080);
    cpulse(2'b10);
    out_chk(9'h18c, 9'h004, "periph held");
    secondary_clock_run <= 1'b1;
    cyc(4);
    out_chk(9'h1ef, 9'h0a5, "secondary idle");
    irq <= 8'h01;
    wake_chk(1, "irq wake vector");
    out_chk(9'h1ef, 9'h1a5, "secondary run");
    rdc(ADDR_POWER_CTRL, 32'h0000_000b, "select kept");
    $display("done t_sec");
  endtask : t_sec

  task automatic t_rc;
    bus(1'b1, ADDR_INT_CTRL, 32'h0000_0000);
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0011);
    cpulse(2'b10);
    out_chk(9'h1de, 9'h090, "internal idle");
    irq <= 8'h01;
    wake_chk(0, "irq wake no vector");
    out_chk(9'h1de, 9'h190, "internal run");
    rdc(ADDR_POWER_CTRL, 32'h0000_0011, "select kept");
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0017);
    cpulse(2'b10);
    out_chk(9'h18c, 9'h08c, "internal select 11 idle");
    rpulse(3'b001);
    out_chk(9'h14f, 9'h10c, "reset exit");
    state_chk(3'h0, "reset exit state");
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0005);
    cpulse(2'b10);
    irq <= 8'h01;
    wake_chk(0, "external primary wake");
    bus(1'b1, ADDR_POWER_CTRL, 32'h0000_0004);
    pext <= 1'b0;
    pready <= 1'b0;
    cpulse(2'b10);
    irq <= 8'h01;
    cyc(2);
    state_chk(3'h3, "start-up wait");
    pready <= 1'b1;
    wake_chk(0, "start-up wake");
    out_chk(9'h142, 9'h142, "primary running");
    $display("done t_rc");
  endtask : t_rc

  initial begin
    #300000;
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_status();
    t_sleep();
    t_sec();
    t_rc();
    give_verdict();
  end
endmodule : tb_top

/* File: verilog/iers_pkg.sv */
// Purpose: Shared constants and types for the idle exit and reset status block
// Assumes: 100 MHz hclk, AHB-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package iers_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CPU_WAKE_DELAY_NS = 100;
  localparam int unsigned CPU_WAKE_CYCLES_DEF =
    (CPU_WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_POWER_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MODE_STATUS = 8'h10;

  // reset_cause_status fields
  localparam int unsigned RCS_IRQ_PRIORITY = 7;
  localparam int unsigned RCS_CONFIG_MISMATCH = 5;
  localparam int unsigned RCS_RESET_INSTR = 4;
  localparam int unsigned RCS_WDT_TIMEOUT = 3;
  localparam int unsigned RCS_POWER_DOWN = 2;
  localparam int unsigned RCS_POWER_ON = 1;
  localparam int unsigned RCS_BROWN_OUT = 0;
  localparam logic [7:0] RCS_RESET_VALUE = 8'h3c;
  localparam logic [7:0] RCS_WRITE_MASK = 8'hb3;

  // power_ctrl fields
  localparam int unsigned PC_IDLE_SEL = 0;
  localparam int unsigned PC_CLK_SEL_LO = 1;
  localparam int unsigned PC_SEC_OSC_EN = 3;
  localparam int unsigned PC_WDT_EN = 4;
  localparam int unsigned PC_FSCM_EN = 5;
  localparam logic [5:0] PC_RESET_VALUE = 6'h00;

  // interrupt_control_reg field
  localparam int unsigned IC_GLOBAL_EN = 7;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_INTERNAL_ALT = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_PRIMARY = 2'h2;
  localparam logic [1:0] SEL_INTERNAL = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_OST = 3'b011,
    ST_WAKE = 3'b100
  } iers_state_t;

  typedef struct packed {
    logic sleep_instr;
    logic watchdog_clear_instruction_instr;
  } iers_cpu_evt_t;

  typedef struct packed {
    logic brown_out;
    logic config_mismatch;
    logic reset_instr;
  } iers_rst_evt_t;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic primary_osc_en;
    logic secondary_osc_en;
    logic internal_rc_en;
    logic [1:0] source;
  } iers_clk_ctl_t;

endpackage : iers_pkg

/* File: verilog/iers_top.sv */
// Purpose: Idle and sleep entry, wake and reset exit, reset cause status register
// Assumes: Single hclk domain; event inputs are one-cycle pulses synchronous to hclk
// Notes: hresetn is the power-on reset; other resets arrive as event pulses
// Notes on behaviour
// - Sleep with idle select stops CPU clock; peripherals run on selected source.
// - Entering secondary idle stops primary, clears primary flag, sets secondary flag.
// - Wake from secondary idle resumes CPU on secondary; select bits untouched.
// - Sleep toward secondary idle is ignored while secondary oscillator disabled.
// - Peripheral clocks held off until enabled secondary oscillator is running.
// - Idle with internal select stops primary and clears primary flag.
// - Wake from internal idle resumes CPU on internal; select bits untouched.
// - Internal RC keeps running when watchdog or fail-safe monitor enabled.
// - Any enabled interrupt flag starts exit from idle or sleep.
// - After interrupt wake, branch to vector only if global enable set.
// - Every interrupt or time-out exit waits the CPU wake delay, then execution restarts.
// - Watchdog time-out wakes from idle or sleep; in run it resets.
// - Sleep, watchdog clear or fail-safe clock loss clears watchdog.
// - Reset ending any mode leaves device running from internal RC.
// - Start-up timer skipped from primary idle or external primary clock.
// - Status bit 7 is priority enable, reset 0; bit 6 reads 0.
// - Mismatch clears bit 5; software writes it back to one.
// - Reset instruction clears bit 4; power-up or firmware sets it.
// - Bit 3 set by power-up, watchdog clear, sleep; cleared by time-out.
// - Bit 2 set by power-up or watchdog clear; cleared by sleep.
// - Power-on reset clears bit 1; firmware sets it again.
// - Brown-out clears bit 0; reads zero while regulator disabled.
// - Sleep without idle select stops oscillator and clears clock flags.
// - Select 10 primary, 11 internal, 01 secondary.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module iers_top #(
  parameter int unsigned IRQ_W = 8,
  parameter int unsigned WAKE_CYCLES = iers_pkg::CPU_WAKE_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [iers_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire iers_pkg::iers_cpu_evt_t cpu_evt,
  input wire iers_pkg::iers_rst_evt_t rst_evt,
  input wire logic wdt_timeout,
  input wire logic [IRQ_W-1:0] irq_flags,
  input wire logic sec_osc_running,
  input wire logic primary_osc_ready,
  input wire logic primary_external_clock,
  input wire logic regulator_enable,
  input wire logic clock_loss,
  output iers_pkg::iers_clk_ctl_t clk_ctl,
  output logic primary_clock_running_flag,
  output logic secondary_clock_active_flag,
  output logic wake_resume,
  output logic vector_branch,
  output logic watchdog_clear,
  output logic watchdog_reset
);
  import iers_pkg::*;

  localparam int unsigned CNT_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYCLES - 1);

  if (WAKE_CYCLES < 1 || IRQ_W < 1 || IRQ_W > 32) begin : g_bad_param
    $error("iers_top: unsupported parameter values");
  end

  function automatic logic is_internal(input logic [1:0] sel);
    is_internal = (sel == SEL_INTERNAL) || (sel == SEL_INTERNAL_ALT);
  endfunction : is_internal

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend;
  logic rd_wait;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] reset_cause_status;
  logic [5:0] power_ctrl;
  logic global_interrupt_enable;
  logic [IRQ_W-1:0] irq_enable;
  iers_state_t state;
  logic [1:0] cur_src;
  logic by_irq;

  wire take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire wr_rcs = wr_pend && (addr_q == ADDR_RESET_CAUSE);
  wire wr_pc = wr_pend && (addr_q == ADDR_POWER_CTRL);
  wire wr_ic = wr_pend && (addr_q == ADDR_INT_CTRL);
  wire wr_ie = wr_pend && (addr_q == ADDR_IRQ_ENABLE);
  wire [31:0] rd_mux =
    (addr_q == ADDR_RESET_CAUSE) ? {24'h00_0000, reset_cause_status} :
    (addr_q == ADDR_POWER_CTRL) ? {26'h000_0000, power_ctrl} :
    (addr_q == ADDR_INT_CTRL) ? {24'h00_0000, global_interrupt_enable, 7'h00} :
    (addr_q == ADDR_IRQ_ENABLE) ? 32'(irq_enable) :
    (addr_q == ADDR_MODE_STATUS) ? {27'h000_0000, by_irq, state, 1'b0} :
    32'h0000_0000;

  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      addr_q <= ADDR_RESET_CAUSE;
    end else begin
      wr_pend <= take && hwrite;
      rd_wait <= take && !hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // Read data sampled one cycle late so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire idle_sel = power_ctrl[PC_IDLE_SEL];
  wire [1:0] clk_sel = power_ctrl[PC_CLK_SEL_LO +: 2];
  wire sec_en = power_ctrl[PC_SEC_OSC_EN];
  wire wdt_en = power_ctrl[PC_WDT_EN];
  wire fscm_en = power_ctrl[PC_FSCM_EN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_ctrl <= PC_RESET_VALUE;
      global_interrupt_enable <= 1'b0;
      irq_enable <= '0;
    end else begin
      if (wr_pc) begin
        power_ctrl <= hwdata[5:0];
      end
      if (wr_ic) begin
        global_interrupt_enable <= hwdata[IC_GLOBAL_EN];
      end
      if (wr_ie) begin
        irq_enable <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-managed mode sequencer
  // ----------------------------------------------------------------
  wire run_reset = (state == ST_RUN) && wdt_timeout;
  wire soft_reset = rst_evt.brown_out || rst_evt.config_mismatch ||
                    rst_evt.reset_instr || run_reset;
  wire irq_wake = |(irq_flags & irq_enable);
  wire wake_evt = irq_wake || wdt_timeout;
  wire sleep_req = (state == ST_RUN) && cpu_evt.sleep_instr && !soft_reset;
  wire sec_refused = idle_sel && (clk_sel == SEL_SECONDARY) && !sec_en;
  wire enter_idle = sleep_req && idle_sel && !sec_refused;
  wire enter_sleep = sleep_req && !idle_sel;
  wire needs_ost = (clk_sel == SEL_PRIMARY) && !primary_external_clock;
  logic [CNT_W-1:0] wake_cnt;
  logic primary_on;
  iers_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (enter_idle) begin
          next_state = ST_IDLE;
        end else if (enter_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      ST_IDLE: begin
        if (wake_evt) begin
          next_state = ST_WAKE;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          next_state = needs_ost ? ST_OST : ST_WAKE;
        end
      end
      ST_OST: begin
        if (primary_osc_ready) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_cnt == '0) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (soft_reset) begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_RUN;
      wake_cnt <= '0;
      by_irq <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_WAKE && next_state == ST_WAKE) begin
        wake_cnt <= WAKE_LOAD;
      end else if (state == ST_WAKE && wake_cnt != '0) begin
        wake_cnt <= wake_cnt - 1'b1;
      end
      if ((state == ST_IDLE || state == ST_SLEEP) && wake_evt) begin
        by_irq <= irq_wake;
      end
    end
  end

  // Clock source and oscillator status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_src <= SEL_INTERNAL;
      primary_on <= 1'b0;
      primary_clock_running_flag <= 1'b0;
      secondary_clock_active_flag <= 1'b0;
    end else if (soft_reset) begin
      cur_src <= SEL_INTERNAL;
      primary_on <= 1'b0;
      primary_clock_running_flag <= 1'b0;
      secondary_clock_active_flag <= 1'b0;
    end else if (enter_idle) begin
      cur_src <= clk_sel;
      primary_on <= (clk_sel == SEL_PRIMARY);
      primary_clock_running_flag <= (clk_sel == SEL_PRIMARY);
      secondary_clock_active_flag <= (clk_sel == SEL_SECONDARY);
    end else if (enter_sleep) begin
      primary_on <= 1'b0;
      primary_clock_running_flag <= 1'b0;
      secondary_clock_active_flag <= 1'b0;
    end else if (state == ST_SLEEP && wake_evt) begin
      cur_src <= clk_sel;
      primary_on <= (clk_sel == SEL_PRIMARY);
      primary_clock_running_flag <= (clk_sel == SEL_PRIMARY) && !needs_ost;
      secondary_clock_active_flag <= (clk_sel == SEL_SECONDARY);
    end else if (state == ST_OST && primary_osc_ready) begin
      primary_clock_running_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and wake pulses
  // ----------------------------------------------------------------
  wire sec_hold = (cur_src == SEL_SECONDARY) && !sec_osc_running;
  wire periph_on = (state == ST_RUN) || (state == ST_WAKE) ||
                   (state == ST_IDLE && !sec_hold);

  assign clk_ctl.cpu_clock_en = (state == ST_RUN);
  assign clk_ctl.periph_clock_en = periph_on;
  assign clk_ctl.primary_osc_en = primary_on;
  assign clk_ctl.secondary_osc_en = sec_en;
  assign clk_ctl.internal_rc_en = wdt_en || fscm_en ||
                                  (is_internal(cur_src) && state != ST_SLEEP);
  assign clk_ctl.source = cur_src;
  wire resume_now = (state == ST_WAKE) && (wake_cnt == '0) && !soft_reset;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_resume <= 1'b0;
      vector_branch <= 1'b0;
      watchdog_clear <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      wake_resume <= resume_now;
      vector_branch <= resume_now && by_irq && global_interrupt_enable;
      watchdog_clear <= cpu_evt.sleep_instr || cpu_evt.watchdog_clear_instruction_instr ||
                        (clock_loss && fscm_en);
      watchdog_reset <= run_reset;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause status
  // ----------------------------------------------------------------
  logic [7:0] next_rcs;

  // Hardware events are applied after the write so they win
  always_comb begin
    next_rcs = reset_cause_status;
    if (wr_rcs) begin
      next_rcs = (hwdata[7:0] & RCS_WRITE_MASK) |
                 (reset_cause_status & ~RCS_WRITE_MASK);
    end
    if (cpu_evt.watchdog_clear_instruction_instr) begin
      next_rcs[RCS_WDT_TIMEOUT] = 1'b1;
      next_rcs[RCS_POWER_DOWN] = 1'b1;
    end
    if (cpu_evt.sleep_instr) begin
      next_rcs[RCS_WDT_TIMEOUT] = 1'b1;
      next_rcs[RCS_POWER_DOWN] = 1'b0;
    end
    if (wdt_timeout) begin
      next_rcs[RCS_WDT_TIMEOUT] = 1'b0;
    end
    if (rst_evt.config_mismatch) begin
      next_rcs[RCS_CONFIG_MISMATCH] = 1'b0;
    end
    if (rst_evt.reset_instr) begin
      next_rcs[RCS_RESET_INSTR] = 1'b0;
    end
    if (rst_evt.brown_out) begin
      next_rcs[RCS_BROWN_OUT] = 1'b0;
      next_rcs[RCS_WDT_TIMEOUT] = 1'b1;
      next_rcs[RCS_POWER_DOWN] = 1'b1;
    end
    if (!regulator_enable) begin
      next_rcs[RCS_BROWN_OUT] = 1'b0;
    end
    next_rcs[6] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_status <= RCS_RESET_VALUE;
    end else begin
      reset_cause_status <= next_rcs;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sec_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && cpu_evt.sleep_instr && sec_refused && !soft_reset)
      |=> (state == ST_RUN))
    else $error("sleep toward disabled secondary idle not ignored");
  sec_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (enter_idle && clk_sel == SEL_SECONDARY)
      |=> (secondary_clock_active_flag && !primary_clock_running_flag
           && !clk_ctl.primary_osc_en && state == ST_IDLE))
    else $error("secondary idle entry flags wrong");
  rc_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (enter_idle && is_internal(clk_sel))
      |=> (!primary_clock_running_flag && !clk_ctl.primary_osc_en))
    else $error("internal idle entry left primary running");
  periph_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_IDLE && cur_src == SEL_SECONDARY && !sec_osc_running)
      |-> !clk_ctl.periph_clock_en)
    else $error("peripheral clock before secondary oscillator runs");
  idle_cpu_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_IDLE) |-> (!clk_ctl.cpu_clock_en && clk_ctl.source == cur_src))
    else $error("cpu clocked in idle");
  sleep_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    enter_sleep |=> (state == ST_SLEEP && !primary_clock_running_flag
                     && !secondary_clock_active_flag && !clk_ctl.periph_clock_en))
    else $error("sleep entry did not stop clocks");
  wake_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_IDLE && irq_wake && !soft_reset) |=> (state == ST_WAKE))
    else $error("enabled interrupt did not start wake");
  wake_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    resume_now |=> (wake_resume && state == ST_RUN && clk_ctl.cpu_clock_en))
    else $error("execution did not restart after wake delay");
  vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    vector_branch |-> (wake_resume && global_interrupt_enable))
    else $error("vector branch without global enable");
  wdt_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && wdt_timeout)
      |=> (watchdog_reset && !reset_cause_status[RCS_WDT_TIMEOUT]))
    else $error("run-mode time-out did not reset");
  wdt_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_evt.sleep_instr || cpu_evt.watchdog_clear_instruction_instr) |=> watchdog_clear)
    else $error("watchdog not cleared");
  reset_rc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset |=> (state == ST_RUN && cur_src == SEL_INTERNAL && !primary_on))
    else $error("reset did not select internal oscillator");
  ost_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_SLEEP && wake_evt && !soft_reset && !needs_ost)
      |=> (state == ST_WAKE))
    else $error("start-up wait not skipped");
  pd_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_evt.sleep_instr && !rst_evt.brown_out)
      |=> (!reset_cause_status[RCS_POWER_DOWN]))
    else $error("power-down flag not cleared by sleep");
  bor_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !regulator_enable |=> !reset_cause_status[RCS_BROWN_OUT])
    else $error("brown-out flag set with regulator off");
  rc_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_en || fscm_en) |-> clk_ctl.internal_rc_en)
    else $error("internal oscillator stopped while needed");

endmodule : iers_top
